/* File: hw/bcd_add_and_decode.sv */
// Purpose: Decode and execute one slice of the core instruction set.
// Assumes: Operands and opcode bytes are presented with start; all inputs share clk.
// Notes: Undefined flags read back with their incoming value and are flagged undef.
// Function
// - Opcode 37 adjusts byte accumulator after add, 8 clocks, updates A and C.
// - D5 0A adjusts word accumulator before divide, 15 clocks, S Z P set.
// - D4 0A adjusts word accumulator after multiply, 19 clocks, S Z P set.
// - Opcode 3F adjusts byte accumulator after subtract, 7 clocks, updates A and C.
// - Opcodes 14 and 15 add immediate plus carry to accumulator, 3 or 4 clocks.
// - Group opcodes reg 2 add immediate plus carry; 4/16, narrow word memory 20.
// - Opcodes 10 to 13 add with carry register forms; 3/10, narrow word 14.
// - Add with carry updates O S Z A P C; D I T unchanged.
// - Opcodes 04, 05 and group reg 0 decode plain add with stated clocks.
// - Opcodes 00 to 03 plain add register forms; 3/10, narrow word 14.
// - Plain add updates O S Z A P C from sum; D I T kept.
// - Opcodes 24, 25 and group reg 4 decode logical AND with clocks.
// - Opcodes 20 to 23 AND register forms; 3/10, narrow word 14.
// - AND clears O and C, sets S Z P, A undefined.
`timescale 1ns/1ps
module bcd_add_and_decode (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Instruction request.
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] modrm,
  input wire logic narrow_bus,
  // Operands.
  input wire logic [15:0] word_accumulator,
  input wire logic [15:0] src_operand,
  input wire logic [15:0] imm_operand,
  input wire logic [5:0] flags_in,
  // Results.
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [15:0] result,
  output logic result_word,
  output logic [5:0] flags_out,
  output logic [5:0] flags_undef,
  output logic [4:0] cycles
);
  // Cycle count selection: register form first, memory form second.
  function automatic logic [4:0] pick_cycles(input logic [7:0] m, input logic [4:0] reg_c,
                                             input logic [4:0] mem_c);
    pick_cycles = (m[7:6] == bcd_add_pkg::MOD_REG) ? reg_c : mem_c;
  endfunction

  // Even parity of the low byte.
  function automatic logic parity8(input logic [7:0] v);
    parity8 = ~^v;
  endfunction

  bcd_add_pkg::seq_state_e state_r, state_nxt;
  logic [4:0] count_r, count_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, illegal_r, illegal_nxt;
  logic [15:0] result_r, result_nxt;
  logic word_r, word_nxt;
  logic [5:0] flags_r, flags_nxt, undef_r, undef_nxt;
  logic [4:0] cycles_r, cycles_nxt;

  // Decode results.
  bcd_add_pkg::op_class_e cls;
  logic dec_word, dec_ok, to_rm, use_imm, sign_ext;
  logic [4:0] dec_cyc;

  // Opcode decode into class, width and clock count.
  always_comb begin
    cls = bcd_add_pkg::OPC_NONE;
    dec_word = 1'b0;
    dec_ok = 1'b1;
    to_rm = 1'b0;
    use_imm = 1'b0;
    sign_ext = 1'b0;
    dec_cyc = 5'd0;
    if (opcode == bcd_add_pkg::OP_ADJ_ADD) begin
      cls = bcd_add_pkg::OPC_AAA;
      dec_cyc = bcd_add_pkg::CYC_ADJ_ADD;
    end else if (opcode == bcd_add_pkg::OP_ADJ_SUB) begin
      cls = bcd_add_pkg::OPC_AAS;
      dec_cyc = bcd_add_pkg::CYC_ADJ_SUB;
    end else if (opcode == bcd_add_pkg::OP_ADJ_DIV && modrm == bcd_add_pkg::OP_ADJ_SECOND) begin
      cls = bcd_add_pkg::OPC_AAD;
      dec_word = 1'b1;
      dec_cyc = bcd_add_pkg::CYC_ADJ_DIV;
    end else if (opcode == bcd_add_pkg::OP_ADJ_MUL && modrm == bcd_add_pkg::OP_ADJ_SECOND) begin
      cls = bcd_add_pkg::OPC_AAM;
      dec_word = 1'b1;
      dec_cyc = bcd_add_pkg::CYC_ADJ_MUL;
    end else if (opcode == bcd_add_pkg::OP_ADC_IMM_B || opcode == bcd_add_pkg::OP_ADC_IMM_W ||
                 opcode == bcd_add_pkg::OP_ADD_IMM_B || opcode == bcd_add_pkg::OP_ADD_IMM_W ||
                 opcode == bcd_add_pkg::OP_AND_IMM_B || opcode == bcd_add_pkg::OP_AND_IMM_W) begin
      // Accumulator immediate forms.
      cls = (opcode[5:4] == 2'h1) ? bcd_add_pkg::OPC_ADC :
            (opcode[5:4] == 2'h2) ? bcd_add_pkg::OPC_AND : bcd_add_pkg::OPC_ADD;
      dec_word = opcode[0];
      use_imm = 1'b1;
      dec_cyc = opcode[0] ? bcd_add_pkg::CYC_IMM_W : bcd_add_pkg::CYC_IMM_B;
    end else if (opcode == bcd_add_pkg::OP_GRP_B || opcode == bcd_add_pkg::OP_GRP_W ||
                 opcode == bcd_add_pkg::OP_GRP_SX) begin
      // Immediate group: reg field picks the operation.
      if (modrm[5:3] == bcd_add_pkg::REG_ADD) begin
        cls = bcd_add_pkg::OPC_ADD;
      end else if (modrm[5:3] == bcd_add_pkg::REG_ADC) begin
        cls = bcd_add_pkg::OPC_ADC;
      end else if (modrm[5:3] == bcd_add_pkg::REG_AND) begin
        cls = bcd_add_pkg::OPC_AND;
      end else begin
        dec_ok = 1'b0;
      end
      dec_word = opcode[0];
      sign_ext = (opcode == bcd_add_pkg::OP_GRP_SX);
      use_imm = 1'b1;
      to_rm = 1'b1;
      dec_cyc = pick_cycles(modrm, bcd_add_pkg::CYC_GRP_REG,
                            (opcode[0] && narrow_bus) ? bcd_add_pkg::CYC_GRP_MEM_NW :
                            bcd_add_pkg::CYC_GRP_MEM);
    end else if (opcode[7:2] == bcd_add_pkg::OP_ADD_RM ||
                 opcode[7:2] == bcd_add_pkg::OP_ADC_RM ||
                 opcode[7:2] == bcd_add_pkg::OP_AND_RM) begin
      // Register with register-or-memory forms, upper six bits pick the operation.
      cls = (opcode[7:2] == bcd_add_pkg::OP_ADC_RM) ? bcd_add_pkg::OPC_ADC :
            (opcode[7:2] == bcd_add_pkg::OP_AND_RM) ? bcd_add_pkg::OPC_AND :
            bcd_add_pkg::OPC_ADD;
      dec_word = opcode[0];
      to_rm = ~opcode[1];
      dec_cyc = pick_cycles(modrm, bcd_add_pkg::CYC_RM_REG,
                            (opcode[0] && narrow_bus) ? bcd_add_pkg::CYC_RM_MEM_NW :
                            bcd_add_pkg::CYC_RM_MEM);
    end else begin
      dec_ok = 1'b0;
    end
  end

  // Datapath: operands, sums and adjusted accumulator.
  logic [15:0] opa, opb;
  logic [16:0] sum;
  logic [4:0] nib;
  logic cin;
  logic [15:0] calc;
  logic [5:0] fcalc, ucalc;
  logic [7:0] al_adj, ah_adj, quo, rem;
  logic adj_hit, zr;

  always_comb begin
    opa = to_rm ? src_operand : word_accumulator;
    opb = use_imm ? (sign_ext ? {{8{imm_operand[7]}}, imm_operand[7:0]} : imm_operand) :
          src_operand;
    if (!dec_word) begin
      opa = {8'h00, opa[7:0]};
      opb = {8'h00, opb[7:0]};
    end
    if (to_rm && !use_imm) begin
      opa = dec_word ? word_accumulator : {8'h00, word_accumulator[7:0]};
    end
    cin = (cls == bcd_add_pkg::OPC_ADC) ? flags_in[bcd_add_pkg::FL_C] : 1'b0;
    sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
    nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    adj_hit = (word_accumulator[3:0] > 4'h9) || flags_in[bcd_add_pkg::FL_A];
    al_adj = word_accumulator[7:0];
    ah_adj = word_accumulator[15:8];
    quo = word_accumulator[7:0] / 8'h0a;
    rem = word_accumulator[7:0] % 8'h0a;
    calc = 16'h0000;
    fcalc = flags_in;
    ucalc = 6'h00;
    case (cls)
      bcd_add_pkg::OPC_ADD, bcd_add_pkg::OPC_ADC: begin
        calc = dec_word ? sum[15:0] : {8'h00, sum[7:0]};
        fcalc[bcd_add_pkg::FL_C] = dec_word ? sum[16] : sum[8];
        fcalc[bcd_add_pkg::FL_A] = nib[4];
        fcalc[bcd_add_pkg::FL_O] = dec_word ?
          ((opa[15] == opb[15]) && (sum[15] != opa[15])) :
          ((opa[7] == opb[7]) && (sum[7] != opa[7]));
      end
      bcd_add_pkg::OPC_AND: begin
        calc = opa & opb;
        fcalc[bcd_add_pkg::FL_O] = 1'b0;
        fcalc[bcd_add_pkg::FL_C] = 1'b0;
        ucalc[bcd_add_pkg::FL_A] = 1'b1;
      end
      bcd_add_pkg::OPC_AAA, bcd_add_pkg::OPC_AAS: begin
        if (adj_hit) begin
          al_adj = (cls == bcd_add_pkg::OPC_AAA) ? word_accumulator[7:0] + 8'h06 :
                   word_accumulator[7:0] - 8'h06;
          ah_adj = (cls == bcd_add_pkg::OPC_AAA) ? word_accumulator[15:8] + 8'h01 :
                   word_accumulator[15:8] - 8'h01;
        end
        calc = {ah_adj, 4'h0, al_adj[3:0]};
        fcalc[bcd_add_pkg::FL_A] = adj_hit;
        fcalc[bcd_add_pkg::FL_C] = adj_hit;
        ucalc = 6'h3f;
        ucalc[bcd_add_pkg::FL_A] = 1'b0;
        ucalc[bcd_add_pkg::FL_C] = 1'b0;
      end
      bcd_add_pkg::OPC_AAD: begin
        calc = {8'h00, 8'(word_accumulator[15:8] * 8'h0a + word_accumulator[7:0])};
        ucalc[bcd_add_pkg::FL_O] = 1'b1;
        ucalc[bcd_add_pkg::FL_A] = 1'b1;
        ucalc[bcd_add_pkg::FL_C] = 1'b1;
      end
      bcd_add_pkg::OPC_AAM: begin
        calc = {quo, rem};
        ucalc[bcd_add_pkg::FL_O] = 1'b1;
        ucalc[bcd_add_pkg::FL_A] = 1'b1;
        ucalc[bcd_add_pkg::FL_C] = 1'b1;
      end
      default: begin
        calc = 16'h0000;
      end
    endcase
    zr = (dec_word && cls != bcd_add_pkg::OPC_AAM && cls != bcd_add_pkg::OPC_AAD) ?
         (calc == 16'h0000) : (calc[7:0] == 8'h00);
    if (cls != bcd_add_pkg::OPC_AAA && cls != bcd_add_pkg::OPC_AAS) begin
      // Sign, zero and parity follow the result.
      fcalc[bcd_add_pkg::FL_S] = (dec_word && cls != bcd_add_pkg::OPC_AAM &&
                                  cls != bcd_add_pkg::OPC_AAD) ? calc[15] : calc[7];
      fcalc[bcd_add_pkg::FL_Z] = zr;
      fcalc[bcd_add_pkg::FL_P] = parity8(calc[7:0]);
    end
  end

  // Sequencer: hold busy for the decoded clock count, then pulse done.
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    illegal_nxt = illegal_r;
    result_nxt = result_r;
    word_nxt = word_r;
    flags_nxt = flags_r;
    undef_nxt = undef_r;
    cycles_nxt = cycles_r;
    case (state_r)
      bcd_add_pkg::ST_IDLE: begin
        if (start) begin
          illegal_nxt = ~dec_ok;
          if (dec_ok) begin
            result_nxt = calc;
            word_nxt = dec_word;
            flags_nxt = fcalc;
            undef_nxt = ucalc;
            cycles_nxt = dec_cyc;
            count_nxt = dec_cyc - 5'd1;
            busy_nxt = 1'b1;
            state_nxt = bcd_add_pkg::ST_BUSY;
          end
        end
      end
      bcd_add_pkg::ST_BUSY: begin
        // Count runs from N-1 down to 0, so busy stands for exactly N clocks.
        if (count_r == 5'd0) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = bcd_add_pkg::ST_DONE;
        end else begin
          count_nxt = count_r - 5'd1;
        end
      end
      bcd_add_pkg::ST_DONE: begin
        state_nxt = bcd_add_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = bcd_add_pkg::ST_IDLE;
      end
    endcase
  end

  // Register the sequencer and results.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= bcd_add_pkg::ST_IDLE;
      count_r <= 5'd0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      result_r <= 16'h0000;
      word_r <= 1'b0;
      flags_r <= 6'h00;
      undef_r <= 6'h00;
      cycles_r <= 5'd0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      illegal_r <= illegal_nxt;
      result_r <= result_nxt;
      word_r <= word_nxt;
      flags_r <= flags_nxt;
      undef_r <= undef_nxt;
      cycles_r <= cycles_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign illegal = illegal_r;
  assign result = result_r;
  assign result_word = word_r;
  assign flags_out = flags_r;
  assign flags_undef = undef_r;
  assign cycles = cycles_r;
endmodule

/* File: hw/bcd_add_pkg.sv */
// Purpose: Shared constants for the decimal-adjust, add and logical-AND decode slice.
// Assumes: Opcode bytes arrive already fetched; the bus width variant is a static input.
// Notes: Cycle counts are core clocks for each form.
package bcd_add_pkg;
  // First opcode bytes, adjust second byte, and upper six bits of register forms.
  localparam logic [7:0] OP_ADJ_ADD = 8'h37;
  localparam logic [7:0] OP_ADJ_SUB = 8'h3f;
  localparam logic [7:0] OP_ADJ_DIV = 8'hd5;
  localparam logic [7:0] OP_ADJ_MUL = 8'hd4;
  localparam logic [7:0] OP_ADJ_SECOND = 8'h0a;
  localparam logic [7:0] OP_ADC_IMM_B = 8'h14;
  localparam logic [7:0] OP_ADC_IMM_W = 8'h15;
  localparam logic [7:0] OP_ADD_IMM_B = 8'h04;
  localparam logic [7:0] OP_ADD_IMM_W = 8'h05;
  localparam logic [7:0] OP_AND_IMM_B = 8'h24;
  localparam logic [7:0] OP_AND_IMM_W = 8'h25;
  localparam logic [7:0] OP_GRP_B = 8'h80;
  localparam logic [7:0] OP_GRP_W = 8'h81;
  localparam logic [7:0] OP_GRP_SX = 8'h83;
  localparam logic [5:0] OP_ADD_RM = 6'h00;
  localparam logic [5:0] OP_ADC_RM = 6'h04;
  localparam logic [5:0] OP_AND_RM = 6'h08;
  // Reg field selections of the immediate group, and the mod value of the register form.
  localparam logic [2:0] REG_ADD = 3'h0;
  localparam logic [2:0] REG_ADC = 3'h2;
  localparam logic [2:0] REG_AND = 3'h4;
  localparam logic [1:0] MOD_REG = 2'h3;
  // Clock counts.
  localparam logic [4:0] CYC_ADJ_ADD = 5'd8;
  localparam logic [4:0] CYC_ADJ_DIV = 5'd15;
  localparam logic [4:0] CYC_ADJ_MUL = 5'd19;
  localparam logic [4:0] CYC_ADJ_SUB = 5'd7;
  localparam logic [4:0] CYC_IMM_B = 5'd3;
  localparam logic [4:0] CYC_IMM_W = 5'd4;
  localparam logic [4:0] CYC_GRP_REG = 5'd4;
  localparam logic [4:0] CYC_GRP_MEM = 5'd16;
  localparam logic [4:0] CYC_GRP_MEM_NW = 5'd20;
  localparam logic [4:0] CYC_RM_REG = 5'd3;
  localparam logic [4:0] CYC_RM_MEM = 5'd10;
  localparam logic [4:0] CYC_RM_MEM_NW = 5'd14;
  // Flag vector positions: o s z a p c.
  localparam int FL_O = 5;
  localparam int FL_S = 4;
  localparam int FL_Z = 3;
  localparam int FL_A = 2;
  localparam int FL_P = 1;
  localparam int FL_C = 0;
  // Operation classes.
  typedef enum logic [2:0] {
    OPC_NONE = 3'h0, OPC_ADD = 3'h1, OPC_ADC = 3'h3, OPC_AND = 3'h2,
    OPC_AAA = 3'h6, OPC_AAS = 3'h7, OPC_AAD = 3'h5, OPC_AAM = 3'h4
  } op_class_e;
  // Sequencer states, Gray along idle, busy, done.
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_BUSY = 2'h1, ST_DONE = 2'h3} seq_state_e;
endpackage

/* File: test/bcd_add_and_decode_checker.sv */
// Purpose: Timing and flag checks for the decode slice, bound to its ports.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: The taken opcode is read one edge before busy rises.
`timescale 1ns/1ps
module bcd_add_and_decode_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Request.
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [15:0] word_accumulator,
  input wire logic [15:0] imm_operand,
  // Results.
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic [15:0] result,
  input wire logic [5:0] flags_out,
  input wire logic [5:0] flags_undef,
  input wire logic [4:0] cycles
);
  logic [4:0] run_r;
  logic [4:0] run_nxt;
  // Counts the cycles of the current busy stretch.
  always_comb begin
    run_nxt = busy ? run_r + 5'h01 : 5'h00;
  end
  always_ff @(posedge clk) begin
    run_r <= rst ? 5'h00 : run_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // First busy cycle of a byte add to the accumulator.
  sequence s_add_b;
    $rose(busy) && $past(opcode) == bcd_add_pkg::OP_ADD_IMM_B;
  endsequence
  // Three busy cycles closed by the done pulse.
  sequence s_three_done;
    busy [*3] ##1 (done && !busy);
  endsequence
  property p_busy_cause; $rose(busy) |-> $past(start); endproperty
  property p_busy_len; done |-> run_r == cycles; endproperty
  property p_done_pulse; $fell(busy) && !$past(rst) |-> done ##1 !done; endproperty
  property p_add_time; s_add_b |-> s_three_done; endproperty
  property p_add_sum;
    s_add_b |-> result == {8'h00, 8'($past(word_accumulator) + $past(imm_operand))};
  endproperty
  property p_adjust_add;
    $rose(busy) && $past(opcode) == bcd_add_pkg::OP_ADJ_ADD |->
      cycles == bcd_add_pkg::CYC_ADJ_ADD && flags_undef == 6'h3a;
  endproperty
  property p_and_flags;
    $rose(busy) && $past(opcode) >= 8'h20 && $past(opcode) <= 8'h25 |->
      flags_out[bcd_add_pkg::FL_O] == 1'b0 && flags_out[bcd_add_pkg::FL_C] == 1'b0;
  endproperty
  property p_stand; busy |=> $stable(cycles) && $stable(result); endproperty
  property p_illegal; $rose(illegal) |-> !busy && $past(start); endproperty
  // Each check ties an output to the request or count that caused it.
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without start");
  a_busy_len: assert property (p_busy_len) else $error("busy span differs from cycles");
  a_done_pulse: assert property (p_done_pulse) else $error("done not one pulse");
  a_add_time: assert property (p_add_time) else $error("byte add not three cycles");
  a_add_sum: assert property (p_add_sum) else $error("byte add sum wrong");
  a_adjust_add: assert property (p_adjust_add) else $error("adjust after add wrong");
  a_and_flags: assert property (p_and_flags) else $error("logical AND flags wrong");
  a_stand: assert property (p_stand) else $error("results moved while busy");
  a_illegal: assert property (p_illegal) else $error("illegal without refusal");
endmodule
bind bcd_add_and_decode bcd_add_and_decode_checker u_bcd_add_and_decode_checker (
  .clk, .rst, .start, .opcode, .word_accumulator, .imm_operand, .busy, .done, .illegal,
  .result, .flags_out, .flags_undef, .cycles
);

/* File: test/tb_bcd_add_and_decode.sv */
// Purpose: Self-checking bench for the decimal-adjust, add and AND decode slice.
// Assumes: Inputs move on rising edges; outputs are sampled on falling edges.
// Notes: Accumulator and register operand carry one value, so operand order never matters.
`timescale 1ns/1ps
module tb_bcd_add_and_decode;
  typedef struct {
    logic [7:0] op; logic [7:0] mrm; logic nb; logic [15:0] a; logic [15:0] imm;
    logic [5:0] fin; logic full; logic [15:0] res; logic rw; logic [5:0] fl;
    logic [5:0] un; logic [4:0] cyc;
  } row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic narrow_bus = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] modrm = 8'h00;
  logic [15:0] word_accumulator = 16'h0000;
  logic [15:0] src_operand = 16'h0000;
  logic [15:0] imm_operand = 16'h0000;
  logic [5:0] flags_in = 6'h00;
  logic busy, done, illegal, result_word;
  logic [15:0] result;
  logic [5:0] flags_out, flags_undef;
  logic [4:0] cycles;
  int fails = 0;
  int compares = 0;
  int nbusy;
  logic [2:0] bad [5] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  // Cycle-only forms: opcode, addressing byte, narrow bus, expected count.
  logic [31:0] times [12] = '{32'h14000003, 32'h05000004, 32'h25000004, 32'h0000010a,
    32'h0300010e, 32'h1000000a, 32'h1100010e, 32'h13c00003, 32'h2000000a, 32'h80000110,
    32'h81200114, 32'h83d00004};
  // Full cases: inputs, then result, width, flags, undefined mask and count.
  row_s rows [12] = '{
    '{8'h04, 8'h00, 1'b0, 16'h00ff, 16'h0001, 6'h00, 1'b1, 16'h0000, 1'b0, 6'h0f, 6'h00, 5'd3},
    '{8'h15, 8'h00, 1'b0, 16'h7fff, 16'h0000, 6'h01, 1'b1, 16'h8000, 1'b1, 6'h36, 6'h00, 5'd4},
    '{8'h80, 8'he0, 1'b0, 16'h00f0, 16'h003c, 6'h00, 1'b1, 16'h0030, 1'b0, 6'h02, 6'h04, 5'd4},
    '{8'h81, 8'h10, 1'b1, 16'h1234, 16'h0001, 6'h01, 1'b1, 16'h1236, 1'b1, 6'h02, 6'h00, 5'd20},
    '{8'h83, 8'h00, 1'b0, 16'h0005, 16'h00ff, 6'h00, 1'b1, 16'h0004, 1'b1, 6'h05, 6'h00, 5'd16},
    '{8'h01, 8'h00, 1'b1, 16'h0101, 16'h0101, 6'h00, 1'b1, 16'h0202, 1'b1, 6'h00, 6'h00, 5'd14},
    '{8'h12, 8'hc0, 1'b1, 16'h0080, 16'h0080, 6'h01, 1'b1, 16'h0001, 1'b0, 6'h21, 6'h00, 5'd3},
    '{8'h22, 8'h00, 1'b1, 16'h00ff, 16'h00ff, 6'h3f, 1'b1, 16'h00ff, 1'b0, 6'h16, 6'h04, 5'd10},
    '{8'h37, 8'h00, 1'b0, 16'h000a, 16'h0000, 6'h00, 1'b1, 16'h0100, 1'b0, 6'h05, 6'h3a, 5'd8},
    '{8'h3f, 8'h00, 1'b0, 16'h020b, 16'h0000, 6'h3b, 1'b1, 16'h0105, 1'b0, 6'h3f, 6'h3a, 5'd7},
    '{8'hd5, 8'h0a, 1'b0, 16'h0102, 16'h0000, 6'h00, 1'b1, 16'h000c, 1'b1, 6'h02, 6'h25, 5'd15},
    '{8'hd4, 8'h0a, 1'b0, 16'h000c, 16'h0000, 6'h00, 1'b1, 16'h0102, 1'b1, 6'h00, 6'h25, 5'd19}};
  bcd_add_and_decode u_bcd_add_and_decode (
    .clk, .rst, .start, .opcode, .modrm, .narrow_bus, .word_accumulator, .src_operand,
    .imm_operand, .flags_in, .busy, .done, .illegal, .result, .result_word, .flags_out,
    .flags_undef, .cycles
  );
  // Clock of 20 ns period.
  always #10 clk = ~clk;
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Presents one instruction and holds start for one sampling edge.
  task automatic go(input logic [7:0] op, input logic [7:0] mrm, input logic nb,
                    input logic [15:0] a, input logic [15:0] imm, input logic [5:0] fin);
    @(posedge clk);
    opcode <= op;
    modrm <= mrm;
    narrow_bus <= nb;
    word_accumulator <= a;
    src_operand <= a;
    imm_operand <= imm;
    flags_in <= fin;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  // Waits for done under a bound, counting busy cycles on the way.
  task automatic wt();
    int n = 0;
    nbusy = 0;
    @(negedge clk);
    while (done !== 1'b1 && n < 40) begin
      nbusy += (busy === 1'b1);
      n++;
      @(negedge clk);
    end
    if (n >= 40) check("done wait", 16'h0001, 16'h0000);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A full run needs a few hundred cycles; this limit cuts a hang short.
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    stop_test();
  end
  // Reset, table cases, then refusals, ignored start and a reset mid-run.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("idle", {8'h00, busy, done, illegal, cycles}, 16'h0000);
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].mrm, rows[i].nb, rows[i].a, rows[i].imm, rows[i].fin);
      wt();
      check("cycles", {11'h000, cycles}, {11'h000, rows[i].cyc});
      check("busy span", nbusy[15:0], {11'h000, rows[i].cyc});
      check("flags", {10'h000, flags_out}, {10'h000, rows[i].fl});
      check("undef", {10'h000, flags_undef}, {10'h000, rows[i].un});
      if (rows[i].full) check("result", result, rows[i].res);
      if (rows[i].full) check("width", {15'h0000, result_word}, {15'h0000, rows[i].rw});
    end
    foreach (times[i]) begin
      go(times[i][31:24], times[i][23:16], times[i][8], 16'h0011, 16'h0022, 6'h00);
      wt();
      check("form cycles", {11'h000, cycles}, {11'h000, times[i][4:0]});
    end
    foreach (bad[i]) begin
      go(8'h80, {2'b11, bad[i], 3'b000}, 1'b0, 16'h0011, 16'h0022, 6'h00);
      @(negedge clk);
      check("refused", {14'h0000, illegal, busy}, 16'h0002);
    end
    go(8'h24, 8'h00, 1'b0, 16'h0011, 16'h0022, 6'h00);
    wt();
    check("cleared", {15'h0000, illegal}, 16'h0000);
    go(8'h37, 8'h00, 1'b0, 16'h0003, 16'h0000, 6'h00);
    go(8'h04, 8'h00, 1'b0, 16'h0003, 16'h0000, 6'h00);
    wt();
    check("ignored start", {11'h000, cycles}, {11'h000, bcd_add_pkg::CYC_ADJ_ADD});
    check("adjust result", result, 16'h0003);
    @(negedge clk);
    check("no extra run", {14'h0000, busy, done}, 16'h0000);
    go(8'hd4, 8'h0a, 1'b0, 16'h000c, 16'h0000, 6'h00);
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset mid run", {8'h00, busy, done, illegal, cycles}, 16'h0000);
    check("reset result", result, 16'h0000);
    check("reset flags", {4'h0, flags_undef, flags_out}, 16'h0000);
    go(8'h04, 8'h00, 1'b0, 16'h0001, 16'h0002, 6'h00);
    wt();
    check("after reset", result, 16'h0003);
    stop_test();
  end
endmodule
